// [src/rtc_output_pin_and_power_defaults.sv]
// Notes on behaviour
// (R1) all pin functions off: pin follows control level bit.
// (R2) level bit and frequency test both zero: pin pulled low.
// (R3) pin only pulls low or releases; high comes from external pull-up.
// (R4) first power-up clears watchdog, alarm, battery alarm, square wave, test enables.
// (R5) first power-up sets halt bit, level bit and timestamp flag.
// (R6) battery power-up sets timestamp, clears test enable and watchdog, keeps rest.
// (R7) other control bits undefined after first power-up; software must not rely.
// (R8) alarm flag with alarm enable and no square wave pulls pin low.
// (R9) frequency test toggles pin at 512Hz when oscillator runs and others off.
// (R10) programmed watchdog takes pin over and suppresses frequency test.
// (R11) square wave enable puts selected square wave on pin or removes it.
// (R12) any active function overrides the level bit.
module rtc_output_pin_and_power_defaults
    import rtc_pin_pkg::*;
#(
    parameter int TONE_HALF = TONE_HALF_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       battery_powerup,
    input  wire reg_req_t   reg_req,
    output logic [7:0]      reg_rdata,
    input  wire logic       alarm_match_flag,
    input  wire logic       watchdog_timeout,
    input  wire logic       square_wave_in,
    input  wire logic       multi_function_pin_in,
    output logic            multi_function_pin_out,
    output logic            multi_function_pin_oe_n
);
    pin_ctrl_t   ctrl_ff,  nxt_ctrl;
    alarm_ctrl_t alarm_ff, nxt_alarm;
    wdog_t       wdog_ff,  nxt_wdog;
    logic        oscillator_halt_bit_ff, nxt_oscillator_halt_bit;
    logic        powerdown_timestamp_flag_ff, nxt_powerdown_timestamp_flag;
    logic [15:0] tone_cnt_ff, nxt_tone_cnt;
    logic        tone_wave_ff, nxt_tone_wave;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic        pin_low_ff, nxt_pin_low;
    logic        wdog_armed;
    logic        tone_active;

    // one write decode shared by every register
    function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : wr_hit

    // watchdog beats frequency test; square wave beats alarm
    assign wdog_armed  = (wdog_ff != wdog_t'(ZERO_BYTE));
    assign tone_active = ctrl_ff.freq_test_enable && !oscillator_halt_bit_ff
                         && !alarm_ff.alarm_irq_enable && !alarm_ff.square_wave_enable
                         && !wdog_armed; // R9 R10

    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_alarm = alarm_ff;
        nxt_wdog  = wdog_ff;
        nxt_oscillator_halt_bit      = oscillator_halt_bit_ff;
        nxt_powerdown_timestamp_flag = powerdown_timestamp_flag_ff;
        if (wr_hit(reg_req, PIN_CONTROL_OFS)) begin
            nxt_ctrl = pin_ctrl_t'(reg_req.wdata);
        end
        if (wr_hit(reg_req, WATCHDOG_OFS)) begin
            nxt_wdog = wdog_t'(reg_req.wdata);
        end
        if (wr_hit(reg_req, ALARM_MONTH_OFS)) begin
            nxt_alarm = alarm_ctrl_t'(reg_req.wdata);
        end
        // only the one bit of these registers that matters here is kept
        if (wr_hit(reg_req, SECONDS_OFS)) begin
            nxt_oscillator_halt_bit = reg_req.wdata[HALT_BIT];
        end
        if (wr_hit(reg_req, ALARM_HOUR_OFS)) begin
            nxt_powerdown_timestamp_flag = reg_req.wdata[STAMP_BIT];
        end
        // power-up set beats a software write in the same cycle
        // halt, level and the alarm enables are left as they were
        if (battery_powerup) begin
            nxt_powerdown_timestamp_flag = 1'b1; // R6
            nxt_ctrl.freq_test_enable    = 1'b0; // R6
            nxt_wdog                     = wdog_t'(ZERO_BYTE); // R6
        end
        // srst is the first power-up, so it outranks a battery power-up
        if (srst) begin
            nxt_wdog  = wdog_t'(ZERO_BYTE); // R4
            nxt_alarm = alarm_ctrl_t'(ZERO_BYTE); // R4
            // calibration bits have no promised value; zero is just tidy
            nxt_ctrl  = pin_ctrl_t'(ZERO_BYTE); // R4 R7
            nxt_ctrl.level = 1'b1; // R5
            nxt_oscillator_halt_bit      = 1'b1; // R5
            nxt_powerdown_timestamp_flag = 1'b1; // R5
        end
    end

    // read data stands one cycle, zero otherwise so no stale byte lingers
    always_comb begin
        nxt_rdata = ZERO_BYTE;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                SECONDS_OFS:     nxt_rdata[HALT_BIT] = oscillator_halt_bit_ff;
                PIN_CONTROL_OFS: nxt_rdata = ctrl_ff;
                WATCHDOG_OFS:    nxt_rdata = wdog_ff;
                ALARM_MONTH_OFS: nxt_rdata = alarm_ff;
                ALARM_HOUR_OFS:  nxt_rdata[STAMP_BIT] = powerdown_timestamp_flag_ff;
                default:         nxt_rdata = ZERO_BYTE;
            endcase
        end
        if (srst) begin
            nxt_rdata = ZERO_BYTE;
        end
    end

    // counter idles at zero, so each enable starts a full half period
    // limitation: 16 bits hold half periods of at most 65536 clocks
    always_comb begin
        nxt_tone_cnt  = '0;
        nxt_tone_wave = tone_wave_ff;
        if (tone_active) begin
            if (tone_cnt_ff == 16'(TONE_HALF - 1)) begin
                nxt_tone_wave = !tone_wave_ff; // R9
            end else begin
                nxt_tone_cnt = tone_cnt_ff + 16'h0001;
            end
        end
        if (srst) begin
            nxt_tone_cnt  = '0;
            nxt_tone_wave = 1'b0;
        end
    end

    always_comb begin
        if (alarm_ff.square_wave_enable) begin
            nxt_pin_low = !square_wave_in; // R11 R12
        end else if (alarm_ff.alarm_irq_enable) begin
            nxt_pin_low = alarm_match_flag; // R8 R12
        end else if (wdog_armed) begin
            nxt_pin_low = watchdog_timeout; // R10 R12
        end else if (ctrl_ff.freq_test_enable) begin
            // halted oscillator gives no test tone: pin released
            // registered, so decode changes never glitch the pad
            nxt_pin_low = tone_active && !tone_wave_ff; // R9 R12
        end else begin
            nxt_pin_low = !ctrl_ff.level; // R1 R2
        end
        if (srst) begin
            nxt_pin_low = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        ctrl_ff     <= nxt_ctrl;
        alarm_ff    <= nxt_alarm;
        wdog_ff     <= nxt_wdog;
        oscillator_halt_bit_ff      <= nxt_oscillator_halt_bit;
        powerdown_timestamp_flag_ff <= nxt_powerdown_timestamp_flag;
        tone_cnt_ff  <= nxt_tone_cnt;
        tone_wave_ff <= nxt_tone_wave;
        rdata_ff    <= nxt_rdata;
        pin_low_ff  <= nxt_pin_low;
    end

    assign reg_rdata               = rdata_ff;
    // never driven high, so the line can be shared with other open-drain sources
    assign multi_function_pin_out  = 1'b0; // R3
    assign multi_function_pin_oe_n = !pin_low_ff; // R3

    // pin checks allow for the one edge of the output flop
    a_level_follow: assert property (@(posedge core_clk) disable iff (srst) // R1
        (!ctrl_ff.freq_test_enable && !alarm_ff.alarm_irq_enable
         && !alarm_ff.square_wave_enable && !wdog_armed)
        |=> (multi_function_pin_oe_n == $past(ctrl_ff.level)))
        else $error("pin does not follow level bit");
    a_both_zero_low: assert property (@(posedge core_clk) disable iff (srst) // R2
        (!ctrl_ff.level && !ctrl_ff.freq_test_enable && !alarm_ff.alarm_irq_enable
         && !alarm_ff.square_wave_enable && !wdog_armed) |=> !multi_function_pin_oe_n)
        else $error("pin not pulled low");
    a_never_high: assert property (@(posedge core_clk) // R3
        !multi_function_pin_out)
        else $error("pin driven high");
    a_first_clear: assert property (@(posedge core_clk) // R4
        srst |=> (wdog_ff == wdog_t'(ZERO_BYTE)) && !alarm_ff.alarm_irq_enable
        && !alarm_ff.battery_alarm_enable && !alarm_ff.square_wave_enable
        && !ctrl_ff.freq_test_enable)
        else $error("first power-up clear wrong");
    a_first_set: assert property (@(posedge core_clk) // R5
        srst |=> oscillator_halt_bit_ff && ctrl_ff.level && powerdown_timestamp_flag_ff)
        else $error("first power-up set wrong");
    a_battery_up: assert property (@(posedge core_clk) disable iff (srst) // R6
        (battery_powerup && !reg_req.wr) |=> powerdown_timestamp_flag_ff
        && !ctrl_ff.freq_test_enable && (wdog_ff == wdog_t'(ZERO_BYTE))
        && $stable(alarm_ff) && $stable(oscillator_halt_bit_ff) && $stable(ctrl_ff.level))
        else $error("battery power-up defaults wrong");
    a_alarm_irq: assert property (@(posedge core_clk) disable iff (srst) // R8
        (alarm_ff.alarm_irq_enable && !alarm_ff.square_wave_enable && alarm_match_flag)
        |=> !multi_function_pin_oe_n)
        else $error("alarm interrupt not on pin");
    a_tone_toggle: assert property (@(posedge core_clk) disable iff (srst) // R9
        (tone_active && tone_cnt_ff == 16'(TONE_HALF - 1))
        |=> (tone_wave_ff != $past(tone_wave_ff)))
        else $error("frequency test toggle wrong");
    a_tone_steady: assert property (@(posedge core_clk) disable iff (srst) // R9
        (tone_active && tone_cnt_ff != 16'(TONE_HALF - 1)) |=> $stable(tone_wave_ff))
        else $error("frequency test toggled early");
    a_tone_on_pin: assert property (@(posedge core_clk) disable iff (srst) // R9
        tone_active |=> (multi_function_pin_oe_n == $past(tone_wave_ff)))
        else $error("frequency test not on pin");
    a_halt_release: assert property (@(posedge core_clk) disable iff (srst) // R12
        (ctrl_ff.freq_test_enable && oscillator_halt_bit_ff && !alarm_ff.alarm_irq_enable
         && !alarm_ff.square_wave_enable && !wdog_armed) |=> multi_function_pin_oe_n)
        else $error("halted test tone not released");
    a_batt_over_write: assert property (@(posedge core_clk) disable iff (srst) // R6
        battery_powerup |=> powerdown_timestamp_flag_ff && !ctrl_ff.freq_test_enable
        && (wdog_ff == wdog_t'(ZERO_BYTE)))
        else $error("battery power-up lost to a write");
    a_reset_released: assert property (@(posedge core_clk) // R5
        srst |=> multi_function_pin_oe_n)
        else $error("pin not released after power-up");
    a_wdog_wins: assert property (@(posedge core_clk) disable iff (srst) // R10
        (wdog_armed && ctrl_ff.freq_test_enable && !alarm_ff.square_wave_enable
         && !alarm_ff.alarm_irq_enable && !watchdog_timeout) |=> multi_function_pin_oe_n)
        else $error("frequency test not suppressed");
    a_square_wave: assert property (@(posedge core_clk) disable iff (srst) // R11
        alarm_ff.square_wave_enable |=> (multi_function_pin_oe_n == $past(square_wave_in)))
        else $error("square wave not on pin");
endmodule : rtc_output_pin_and_power_defaults

// [src/rtc_pin_pkg.sv]
package rtc_pin_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] SECONDS_OFS     = 8'h01;
    localparam logic [7:0] PIN_CONTROL_OFS = 8'h08;
    localparam logic [7:0] WATCHDOG_OFS    = 8'h09;
    localparam logic [7:0] ALARM_MONTH_OFS = 8'h0a;
    localparam logic [7:0] ALARM_HOUR_OFS  = 8'h0c;

    // field positions
    localparam int HALT_BIT       = 7;
    localparam int LEVEL_BIT      = 7;
    localparam int TEST_EN_BIT    = 6;
    localparam int ALARM_EN_BIT   = 7;
    localparam int SQUARE_EN_BIT  = 6;
    localparam int BATT_ALARM_BIT = 5;
    localparam int STAMP_BIT      = 6;

    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // frequency test timing
    localparam int CLK_HZ           = 25_000_000;
    localparam int TONE_FREQ_HZ     = 512;
    localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_FREQ_HZ);

    typedef struct packed {
        logic       level;
        logic       freq_test_enable;
        logic [5:0] calib;
    } pin_ctrl_t;

    typedef struct packed {
        logic       alarm_irq_enable;
        logic       square_wave_enable;
        logic       battery_alarm_enable;
        logic [4:0] alarm_month;
    } alarm_ctrl_t;

    typedef struct packed {
        logic [4:0] timeout_multiplier;
        logic       timeout_resolution_high;
        logic       timeout_resolution_low;
    } wdog_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : rtc_pin_pkg

// [verif/pin_pullup_model.sv]
module pin_pullup_model (
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // released pin floats to the pull-up level, never to the last driven value
    assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule : pin_pullup_model

// [verif/rtc_output_pin_and_power_defaults_tb.sv]
module rtc_output_pin_and_power_defaults_tb
    import rtc_pin_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, srst, battery_powerup, alarm_match_flag, watchdog_timeout, square_wave_in;
    logic pin_out, pin_oe_n, pin_level, prev;
    reg_req_t   reg_req;
    logic [7:0] reg_rdata;
    logic [31:0] rnd;
    int num_errors, check_count, cnt;
    localparam int TONE_HALF_TB = 8;

    rtc_output_pin_and_power_defaults #(.TONE_HALF(TONE_HALF_TB))
        u_rtc_output_pin_and_power_defaults (
        .core_clk(core_clk), .srst(srst), .battery_powerup(battery_powerup),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .alarm_match_flag(alarm_match_flag),
        .watchdog_timeout(watchdog_timeout), .square_wave_in(square_wave_in),
        .multi_function_pin_in(pin_level), .multi_function_pin_out(pin_out),
        .multi_function_pin_oe_n(pin_oe_n));
    pin_pullup_model u_pin_pullup_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_level(pin_level));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // battery power-up clears only the test enable of the control byte
    function automatic logic [7:0] batt_ctrl(input logic [7:0] c);
        return {c[7], 1'b0, c[5:0]};
    endfunction : batt_ctrl

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk) reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk) reg_req = '0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk) reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk) reg_req = '0;
        chk(reg_rdata, exp);
    endtask : reg_read

    // pin is checked one edge after the selecting register update
    task automatic pin_is(input logic e);
        @(negedge core_clk);
        chk({7'h00, pin_level}, {7'h00, e});
    endtask : pin_is

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        #(40 * 4000);
        num_errors++;
        end_sim();
    end

    initial begin
        srst = 1'b1; battery_powerup = 1'b0; reg_req = '0; rnd = 32'h3e53;
        alarm_match_flag = 1'b0; watchdog_timeout = 1'b0; square_wave_in = 1'b1;
        num_errors = 0; check_count = 0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) srst = 1'b0;
        chk({7'h00, pin_level}, 8'h01);
        reg_read(PIN_CONTROL_OFS, 8'h80);
        reg_read(SECONDS_OFS, 8'h80);
        reg_read(ALARM_HOUR_OFS, 8'h40);
        reg_read(WATCHDOG_OFS, 8'h00);
        reg_read(ALARM_MONTH_OFS, 8'h00);
        reg_write(PIN_CONTROL_OFS, 8'h00);
        pin_is(1'b0);
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            reg_write(PIN_CONTROL_OFS, {rnd[7], 1'b0, rnd[5:0]});
            pin_is(rnd[7]);
            reg_read(PIN_CONTROL_OFS, {rnd[7], 1'b0, rnd[5:0]});
        end
        reg_write(PIN_CONTROL_OFS, 8'h40);
        pin_is(1'b1);
        reg_write(SECONDS_OFS, 8'h00);
        repeat (2) @(negedge core_clk);
        prev = pin_level; cnt = 0;
        repeat (64) begin
            @(negedge core_clk);
            if (pin_level !== prev) cnt++;
            prev = pin_level;
        end
        chk(cnt[7:0], 8'(64 / TONE_HALF_TB));
        reg_write(WATCHDOG_OFS, 8'h0a);
        repeat (20) pin_is(1'b1);
        @(negedge core_clk) watchdog_timeout = 1'b1;
        pin_is(1'b0);
        @(negedge core_clk) watchdog_timeout = 1'b0;
        reg_write(WATCHDOG_OFS, 8'h00);
        reg_write(PIN_CONTROL_OFS, 8'h00);
        reg_write(ALARM_MONTH_OFS, 8'h80);
        pin_is(1'b1);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            @(negedge core_clk) alarm_match_flag = rnd[3];
            pin_is(~rnd[3]);
        end
        reg_write(ALARM_MONTH_OFS, 8'hc0);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            @(negedge core_clk) square_wave_in = rnd[5];
            pin_is(rnd[5]);
        end
        alarm_match_flag = 1'b0;
        reg_write(SECONDS_OFS, 8'h80);
        reg_write(PIN_CONTROL_OFS, 8'hc5);
        reg_write(WATCHDOG_OFS, 8'hff);
        reg_write(ALARM_MONTH_OFS, 8'he5);
        reg_write(ALARM_HOUR_OFS, 8'h00);
        @(negedge core_clk) battery_powerup = 1'b1;
        @(negedge core_clk) battery_powerup = 1'b0;
        reg_read(PIN_CONTROL_OFS, batt_ctrl(8'hc5));
        reg_read(WATCHDOG_OFS, 8'h00);
        reg_read(ALARM_MONTH_OFS, 8'he5);
        reg_read(SECONDS_OFS, 8'h80);
        reg_read(ALARM_HOUR_OFS, 8'h40);
        // corner: battery power-up in the very cycle of a watchdog write
        @(negedge core_clk) begin
            reg_req = '{wr: 1'b1, rd: 1'b0, addr: WATCHDOG_OFS, wdata: 8'hff};
            battery_powerup = 1'b1;
        end
        @(negedge core_clk) begin
            reg_req = '0;
            battery_powerup = 1'b0;
        end
        reg_read(WATCHDOG_OFS, 8'h00);
        // second first power-up in mid-run, over non-default state
        reg_write(WATCHDOG_OFS, 8'h3c);
        reg_write(SECONDS_OFS, 8'h00);
        reg_write(ALARM_HOUR_OFS, 8'h00);
        @(negedge core_clk) srst = 1'b1;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        chk({7'h00, pin_level}, 8'h01);
        reg_read(WATCHDOG_OFS, 8'h00);
        reg_read(ALARM_MONTH_OFS, 8'h00);
        reg_read(PIN_CONTROL_OFS, 8'h80);
        reg_read(SECONDS_OFS, 8'h80);
        reg_read(ALARM_HOUR_OFS, 8'h40);
        end_sim();
    end
endmodule : rtc_output_pin_and_power_defaults_tb
